// [emr_ctrl.sv]
/*
 * Device side of the mode register write: decodes the command pins,
 * captures address and bank bits into the extended or base register,
 * drives DLL enable and drive strength, and flags the busy window.
 * Assumes the controller keeps banks idle and clock enable high.
 */
`timescale 1ns/10ps
module emr_ctrl (
	// Clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	// Command pins
	input  wire logic                      cs_n,
	input  wire logic                      ras_n,
	input  wire logic                      cas_n,
	input  wire logic                      we_n,
	input  wire logic                      cke,
	input  wire logic [emr_pkg::ADDR_W-1:0] addr,
	input  wire logic [emr_pkg::BANK_W-1:0] ba,
	// Register contents
	output      logic [emr_pkg::REG_W-1:0]  ext_mode_r,
	output      logic [emr_pkg::REG_W-1:0]  base_mode_r,
	output      logic                      ext_valid_r,
	output      logic                      base_valid_r,
	// Controls derived from the extended register
	output      logic                      dll_en,
	output      logic                      drv_weak,
	// Status
	output      logic                      busy,
	output      logic                      cmd_violation_r
);
	localparam int PW = 4 + 1 + emr_pkg::ADDR_W + emr_pkg::BANK_W;

	// Control strobes idle high after reset; inverting trick keeps reset constant
	localparam logic [PW-1:0] PIN_IDLE = {4'hF, 1'b0, 13'h0000, 2'h0};

	logic [PW-1:0] pin_raw;   // Packed pin bundle
	logic [PW-1:0] pin_s;     // Synchronised, reset-biased
	logic [PW-1:0] pin_q;     // Synchronised pin values
	logic          cs_q, ras_q, cas_q, we_q, cke_q;
	logic [emr_pkg::ADDR_W-1:0] addr_q;
	logic [emr_pkg::BANK_W-1:0] ba_q;
	logic          ext_wr, base_wr;
	logic [1:0]    mrd_cnt_r;  // Cycles left in completion window

	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} wr_state_e;
	wr_state_e     state_r, state_nxt;

	assign pin_raw = {cs_n, ras_n, cas_n, we_n, cke, addr, ba};

	// Pins cross into clk_sys through two flip-flops
	emr_sync #(.W(PW)) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       (pin_raw),
		.rst_val (PIN_IDLE),
		.q       (pin_s)
	);
	assign pin_q = pin_s ^ PIN_IDLE;
	assign {cs_q, ras_q, cas_q, we_q, cke_q, addr_q, ba_q} = pin_q;

	// Four strobes low with clock enable high is a mode write
	function automatic logic is_mode_cmd(input logic c, r, a, w, k);
		is_mode_cmd = !c && !r && !a && !w && k;
	endfunction

	// BA0 high picks the extended register, low the base register
	assign ext_wr  = is_mode_cmd(cs_q, ras_q, cas_q, we_q, cke_q) && ba_q[emr_pkg::BA0_BIT];  // R2
	assign base_wr = is_mode_cmd(cs_q, ras_q, cas_q, we_q, cke_q) && !ba_q[emr_pkg::BA0_BIT]; // R9

	// Extended register capture, same cycle as the command
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ext_mode_r  <= emr_pkg::REG_RST;
			ext_valid_r <= 1'b0;
		end else if (ext_wr && state_r == ST_IDLE) begin
			ext_mode_r  <= {addr_q, ba_q}; // R3 R8
			ext_valid_r <= 1'b1;           // R1
		end
	end

	// Base register capture on the same command with BA0 low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			base_mode_r  <= emr_pkg::REG_RST;
			base_valid_r <= 1'b0;
		end else if (base_wr && state_r == ST_IDLE) begin
			base_mode_r  <= {addr_q, ba_q}; // R9
			base_valid_r <= 1'b1;
		end
	end

	// DLL and drive strength follow captured A0 and A1
	assign dll_en   = ext_valid_r &&
		(ext_mode_r[emr_pkg::BANK_W + emr_pkg::DLL_BIT] == emr_pkg::DLL_ON_LVL);  // R7 R10
	assign drv_weak = ext_valid_r &&
		(ext_mode_r[emr_pkg::BANK_W + emr_pkg::DRV_BIT] != emr_pkg::DRV_NORM_LVL); // R6 R10

	// Next state of the completion window
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (ext_wr || base_wr)
					state_nxt = ST_BUSY;
			end
			ST_BUSY: begin
				if (mrd_cnt_r == 2'h0)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Counts the cycle after the command out of the two-cycle window
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			mrd_cnt_r <= 2'h0;
		else if (state_r == ST_IDLE && (ext_wr || base_wr))
			mrd_cnt_r <= emr_pkg::MRD_LAST - 2'h1; // R5
		else if (mrd_cnt_r != 2'h0)
			mrd_cnt_r <= mrd_cnt_r - 2'h1;
	end

	assign busy = (state_r == ST_BUSY);

	// Any command during the window is flagged sticky until reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			cmd_violation_r <= 1'b0;
		else if (busy && !cs_q)
			cmd_violation_r <= 1'b1; // R5
	end

	// Command sequence helpers: an accepted write of either register,
	// and the single busy cycle that follows the command cycle
	sequence s_ext_cmd;
		ext_wr && state_r == ST_IDLE;
	endsequence

	sequence s_base_cmd;
		base_wr && state_r == ST_IDLE;
	endsequence

	sequence s_window;
		busy ##1 !busy;
	endsequence

	// Accepted extended write lands the pin word one edge later
	AST_EXT_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst) // R3
		s_ext_cmd |=> ext_mode_r == $past({addr_q, ba_q}))
		else $error("extended register did not capture address");
	// Extended write leaves the base register alone
	AST_BASE_UNTOUCHED: assert property (@(posedge clk_sys) disable iff (rst) // R2
		s_ext_cmd |=> $stable(base_mode_r))
		else $error("extended write altered base register");
	// Base write lands and leaves the extended register alone
	AST_BASE_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst) // R9
		(base_wr && state_r == ST_IDLE) |=> base_mode_r == $past({addr_q, ba_q}) &&
		$stable(ext_mode_r))
		else $error("base write wrong");
	// Command cycle plus one busy cycle make up the window
	AST_BUSY_TWO: assert property (@(posedge clk_sys) disable iff (rst) // R5
		s_ext_cmd |=> s_window)
		else $error("completion window not two cycles");
	// A0 low turns the DLL on
	AST_DLL: assert property (@(posedge clk_sys) disable iff (rst) // R7
		(s_ext_cmd and !addr_q[emr_pkg::DLL_BIT]) |=> dll_en)
		else $error("DLL not enabled by A0 low");
	// A1 high selects weak drive
	AST_DRV: assert property (@(posedge clk_sys) disable iff (rst) // R6
		(s_ext_cmd and addr_q[emr_pkg::DRV_BIT]) |=> drv_weak)
		else $error("weak drive not selected by A1 high");
	// Clock enable low blocks the extended capture
	AST_NO_CKE: assert property (@(posedge clk_sys) disable iff (rst) // R2
		(!cke_q && $stable(ext_mode_r)) |=> $stable(ext_mode_r) || $past(ext_wr))
		else $error("capture without clock enable");
	// Extended register moves only on an accepted write
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R8
		(!ext_wr || busy) |=> $stable(ext_mode_r))
		else $error("extended register changed without command");
	// Base writes hold off further commands for the same window
	AST_BASE_BUSY: assert property (@(posedge clk_sys) disable iff (rst) // R5
		s_base_cmd |=> s_window)
		else $error("base write window not two cycles");
	// A0 high turns the DLL off
	AST_DLL_OFF: assert property (@(posedge clk_sys) disable iff (rst) // R7
		(s_ext_cmd and addr_q[emr_pkg::DLL_BIT]) |=> !dll_en)
		else $error("DLL still enabled with A0 high");
	// A1 low keeps normal drive
	AST_DRV_NORM: assert property (@(posedge clk_sys) disable iff (rst) // R6
		(s_ext_cmd and !addr_q[emr_pkg::DRV_BIT]) |=> !drv_weak)
		else $error("weak drive selected with A1 low");
	// An accepted extended write marks the register as programmed
	AST_EXT_VALID: assert property (@(posedge clk_sys) disable iff (rst) // R3
		s_ext_cmd |=> ext_valid_r)
		else $error("extended register not marked valid");
	// A mode command inside the window changes neither register
	AST_REFUSE_BUSY: assert property (@(posedge clk_sys) disable iff (rst) // R5
		((ext_wr || base_wr) && busy) |=> $stable(ext_mode_r) && $stable(base_mode_r))
		else $error("mode write accepted inside the completion window");
	// Any selected command inside the window raises the violation flag
	AST_VIOL_SET: assert property (@(posedge clk_sys) disable iff (rst) // R5
		(busy && !cs_q) |=> cmd_violation_r)
		else $error("command inside the window not flagged");
	// Violation flag stays up until reset
	AST_VIOL_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R5
		cmd_violation_r |=> cmd_violation_r)
		else $error("violation flag dropped without reset");
	// Chip select with any strobe high is no mode write
	AST_NON_MODE: assert property (@(posedge clk_sys) disable iff (rst) // R2
		(!cs_q && (ras_q || cas_q || we_q)) |=> $stable(ext_mode_r) && $stable(base_mode_r))
		else $error("partial strobe pattern wrote a mode register");
	// Clock enable low blocks the base capture as well
	AST_NO_CKE_BASE: assert property (@(posedge clk_sys) disable iff (rst) // R9
		!cke_q |=> $stable(base_mode_r))
		else $error("base capture without clock enable");
	// Window state stays one-hot
	AST_STATE_ONEHOT: assert property (@(posedge clk_sys) disable iff (rst) // R5
		$onehot(state_r))
		else $error("window state not one-hot");
endmodule // emr_ctrl

// [emr_ctrl_tb_top.sv]
/*
 * Bench for the mode register path: table of writes, then spacing and reset.
 * Assumes a 20 MHz clock and the host model on the command pins.
 */
`timescale 1ns/10ps
module emr_ctrl_tb_top;
	typedef struct packed {logic ext; logic [12:0] a; logic dll; logic drv;} row_s;
	logic        clk_sys = 1'b0, rst = 1'b1, go = 1'b0, ext = 1'b0;
	logic        part = 1'b0, cke_on = 1'b1;
	logic [12:0] a = 13'h0000;
	logic        cs_n, ras_n, cas_n, we_n, cke, ev, bv, dll_en, drv_weak, busy, viol;
	logic [12:0] addr;
	logic [1:0]  ba;
	logic [14:0] em, bm;
	int          err_count = 0, checks = 0, cyc = 0;
	// Writes and the controls expected after each
	row_s rows [5] = '{'{1'b1, 13'h0000, 1'b1, 1'b0}, '{1'b1, 13'h0001, 1'b0, 1'b0},
		'{1'b1, 13'h0002, 1'b1, 1'b1}, '{1'b0, 13'h0075, 1'b1, 1'b1},
		'{1'b1, 13'h1FFF, 1'b0, 1'b1}};
	emr_host_model i_emr_host_model (.go(go), .ext(ext), .part(part), .cke_on(cke_on),
		.a(a), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
		.addr(addr), .ba(ba));
	emr_ctrl i_emr_ctrl (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .cke(cke), .addr(addr), .ba(ba), .ext_mode_r(em),
		.base_mode_r(bm), .ext_valid_r(ev), .base_valid_r(bv), .dll_en(dll_en),
		.drv_weak(drv_weak), .busy(busy), .cmd_violation_r(viol));
	// Clock, 50 ns period
	always #25 clk_sys = ~clk_sys;
	// Compare and count
	task automatic chk(input string n, input logic [14:0] s, input logic [14:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// One write cycle on the pins
	task automatic issue(input logic x, input logic [12:0] v);
		@(posedge clk_sys);
		#5 go = 1'b1;
		ext = x;
		a = v;
		@(posedge clk_sys);
		#5 go = 1'b0;
	endtask
	// Verdict
	task automatic end_sim();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			end_sim();
		end
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		#5 rst = 1'b0;
		chk("ext_valid", ev, 0);
		foreach (rows[i]) begin
			issue(rows[i].ext, rows[i].a);
			repeat (2) @(posedge clk_sys);
			#5 chk("mode", rows[i].ext ? em : bm, {rows[i].a, 1'b0, rows[i].ext});
			chk("valid", rows[i].ext ? ev : bv, 15'h0001);
			chk("dll_en", dll_en, rows[i].dll);
			chk("drv_weak", drv_weak, rows[i].drv);
			chk("busy", busy, 1);
			@(posedge clk_sys);
			#5 chk("busy_end", busy, 0);
		end
		// Only chip select and row strobe low: not a mode write
		part = 1'b1;
		issue(1'b1, 13'h0000);
		repeat (2) @(posedge clk_sys);
		#5 chk("partial", em, 15'h7FFD);
		chk("partial_busy", busy, 15'h0000);
		// Clock enable low: the mode command is not taken
		part = 1'b0;
		cke_on = 1'b0;
		issue(1'b0, 13'h0000);
		repeat (2) @(posedge clk_sys);
		#5 chk("no_cke", bm, 15'h01D4);
		chk("no_cke_busy", busy, 15'h0000);
		cke_on = 1'b1;
		// Writes two cycles apart are both taken
		issue(1'b1, 13'h0002);
		issue(1'b1, 13'h0001);
		repeat (4) @(posedge clk_sys);
		#5 chk("spaced", em, 15'h0005);
		chk("no_violation", viol, 15'h0000);
		// Second write in the cycle right after the first is refused
		@(posedge clk_sys);
		#5 go = 1'b1;
		a = 13'h0002;
		@(posedge clk_sys);
		#5 a = 13'h0001;
		@(posedge clk_sys);
		#5 go = 1'b0;
		repeat (4) @(posedge clk_sys);
		#5 chk("early", em, 15'h0009);
		chk("violation", viol, 1);
		// Reset in mid-run clears everything
		rst = 1'b1;
		#5 chk("rst", {ev, bv, dll_en, drv_weak, busy, viol}, 0);
		@(posedge clk_sys);
		#5 rst = 1'b0;
		// First write after the second release is taken as usual
		issue(1'b1, 13'h0002);
		repeat (2) @(posedge clk_sys);
		#5 chk("after_rst", em, 15'h0009);
		chk("after_rst_dll", dll_en, 15'h0001);
		end_sim();
	end
endmodule // emr_ctrl_tb_top

// [emr_host_model.sv]
/*
 * Controller model that drives the command pins of the mode register path.
 * Assumes the bench raises go for one or two cycles, just after a rising edge.
 */
`timescale 1ns/10ps
module emr_host_model (
	// Request from the bench
	input  wire logic                       go,
	input  wire logic                       ext,
	input  wire logic                       part,
	input  wire logic                       cke_on,
	input  wire logic [emr_pkg::ADDR_W-1:0] a,
	// Command pins
	output      logic                       cs_n,
	output      logic                       ras_n,
	output      logic                       cas_n,
	output      logic                       we_n,
	output      logic                       cke,
	output      logic [emr_pkg::ADDR_W-1:0] addr,
	output      logic [emr_pkg::BANK_W-1:0] ba
);
	// Clock enable high, banks assumed idle; bench drops it only to test refusal
	assign cke = cke_on;
	// All four strobes low per write; part keeps column strobe and write enable high
	assign cs_n  = ~go;
	assign ras_n = ~go;
	assign cas_n = ~go | part;
	assign we_n  = ~go | part;
	// Address and bank show garbage outside the command cycle
	assign addr = go ? a : ~a;
	assign ba = go ? {1'b0, ext} : {1'b1, ~ext};
	// Bench spaces writes apart, except the back-to-back pair of the early check, and programs before use
endmodule // emr_host_model

// [emr_pkg.sv]
/*
 * Constants for the mode register write path of the memory device:
 * command decode bits, address field positions, reset values, timing.
 * Assumes a single 20 MHz clock domain and no software access.
 */
// Operation
// R1: Controller programs extended register after power-up
// R2: All strobes low, BA0 high: extended write
// R3: Capture A0-A12, BA0, BA1 on command cycle
// R4: Controller keeps banks idle, clock enable high
// R5: Write completes in two clock cycles
// R6: Captured A1 selects normal or weak drive
// R7: Captured A0 enables or disables the DLL
// R8: Rewrite allowed in operation when banks idle
// R9: Same command with BA0 low writes base register
// R10: A0 low DLL on, A1 low normal drive
package emr_pkg;
	localparam int ADDR_W        = 13;          // Address lines A0..A12
	localparam int BANK_W        = 2;           // Bank address lines
	localparam int REG_W         = ADDR_W + BANK_W;
	localparam int BA0_BIT       = 0;           // Selects extended versus base register
	localparam int DLL_BIT       = 0;           // A0 of captured field
	localparam int DRV_BIT       = 1;           // A1 of captured field
	localparam logic [REG_W-1:0] REG_RST = 15'h0000;
	localparam logic DLL_ON_LVL  = 1'b0;        // A0 low enables DLL
	localparam logic DRV_NORM_LVL = 1'b0;       // A1 low is normal drive
	// Completion time, in clock cycles
	localparam int MRD_CYC       = 2;
	localparam logic [1:0] MRD_LAST = 2'(MRD_CYC - 1);
endpackage

// [emr_sync.sv]
/*
 * Two-flop synchroniser for a bus of pin inputs.
 * Assumes the destination clock is clk_sys.
 */
`timescale 1ns/10ps
module emr_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	input  wire logic [W-1:0] rst_val,
	output      logic [W-1:0] q
);
	logic [W-1:0] meta_r; // First stage, read only by second stage

	// Two flip-flop chain; both stages reset to zero, data is XORed with rst_val per bit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d ^ rst_val;
			q      <= meta_r;
		end
	end
endmodule // emr_sync
